/* File: card_timing_pkg.sv */
// constants, register map and phase type for the card cycle sequencer
// assumes a 100 MHz sys_clk and an AXI4-Lite register port with 12-bit addresses
package card_timing_pkg;
  // clocking
  localparam int unsigned SYS_CLK_PERIOD_PS = 10000;
  localparam int unsigned INPUT_CLOCK_PERIOD_PS = 69840;
  localparam int unsigned SYNTH_MUL = 7;
  localparam int unsigned SYNTH_DIV = 4;
  localparam int ACC_W = 20;
  localparam logic [ACC_W-1:0] SYNTH_STEP = ACC_W'(SYS_CLK_PERIOD_PS * SYNTH_MUL);
  localparam logic [ACC_W-1:0] BYPASS_STEP = ACC_W'(SYS_CLK_PERIOD_PS * SYNTH_DIV);
  localparam logic [ACC_W-1:0] TICK_THRESHOLD = ACC_W'(INPUT_CLOCK_PERIOD_PS * SYNTH_DIV);

  // phase counting, in internal clocks
  localparam int COUNT_W = 18;
  localparam int MULT_W = 6;
  localparam int PRESCALE_SHIFT_STEP = 4;
  localparam logic [COUNT_W-1:0] SETUP_ENTRY_SLACK = 18'h00001;
  localparam logic [1:0] WAIT_RELEASE_TICKS = 2'h2;
  localparam logic [1:0] IOIS16_WINDOW_TICKS = 2'h3;

  // register indices; byte address is four times the index
  localparam int AXI_ADDR_W = 12;
  localparam int NUM_TIMING_REGS = 6;
  localparam int REGS_PER_SET = 3;
  localparam logic [7:0] IDX_SETUP_SET0 = 8'h3a;
  localparam logic [7:0] IDX_COMMAND_SET0 = 8'h3b;
  localparam logic [7:0] IDX_RECOVERY_SET0 = 8'h3c;
  localparam logic [7:0] IDX_SETUP_SET1 = 8'h3d;
  localparam logic [7:0] IDX_RECOVERY_SET1 = 8'h3f;
  localparam logic [7:0] IDX_CONTROL = 8'h40;
  localparam logic [7:0] IDX_STATUS = 8'h41;
  localparam logic [7:0] IDX_READ_DATA = 8'h42;
  localparam logic [7:0] IDX_UNMAPPED = 8'hff;

  // reset values
  localparam logic [7:0] SETUP_SET0_RESET = 8'h01;
  localparam logic [7:0] COMMAND_SET0_RESET = 8'h06;
  localparam logic [7:0] RECOVERY_SET0_RESET = 8'h03;
  localparam logic [7:0] TIMING_SET1_RESET = 8'h00;

  // field positions
  localparam int CTRL_BYPASS_BIT = 0;
  localparam int STATUS_PHASE_LSB = 0;
  localparam int STATUS_BUSY_BIT = 2;
  localparam int STATUS_WAIT_EXT_BIT = 3;
  localparam int STATUS_IO16_BIT = 4;
  localparam int STATUS_BYPASS_BIT = 5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_SETUP = 2'h1,
    PH_COMMAND = 2'h3,
    PH_RECOVERY = 2'h2
  } phase_t;

  // prescale code in the upper bits selects 16**code, multiplier in the lower bits
  function automatic logic [COUNT_W-1:0] phase_clocks(input logic [7:0] value);
    logic [COUNT_W-1:0] mult;
    logic [COUNT_W-1:0] prod;
    mult = COUNT_W'(value[MULT_W-1:0]);
    prod = mult << (PRESCALE_SHIFT_STEP * int'(value[7:MULT_W]));
    return prod + COUNT_W'(1);
  endfunction
endpackage

/* File: internal_clock_tick_gen.sv */
// internal clock enable: one sys_clk pulse per internal clock period
// assumes the input clock period constant matches the clock fed to the card controller
`timescale 1ns/1ps
module internal_clock_tick_gen (
  // clock and reset
  input logic sys_clk,
  input logic reset,
  // control
  input logic bypass,
  // enable out
  output logic tick
);
  typedef struct packed {
    logic [card_timing_pkg::ACC_W-1:0] acc;
    logic tick;
  } tick_state_t;

  tick_state_t st;
  tick_state_t next_st;
  logic [card_timing_pkg::ACC_W-1:0] sum;

  // fractional accumulator, so the 4/7 ratio holds on average without a second clock
  always_comb begin
    next_st = st;
    sum = st.acc + (bypass ? card_timing_pkg::BYPASS_STEP : card_timing_pkg::SYNTH_STEP);
    next_st.tick = 1'b0;
    next_st.acc = sum;
    if (sum >= card_timing_pkg::TICK_THRESHOLD) begin
      next_st.acc = sum - card_timing_pkg::TICK_THRESHOLD;
      next_st.tick = 1'b1;
    end
    if (reset) begin
      next_st = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    st <= next_st;
  end

  assign tick = st.tick;
endmodule

/* File: card_reg_axi_slave.sv */
// AXI4-Lite slave front end: word per register index, low byte lane carries data
// assumes the owner decodes indices combinationally and returns read data the same cycle
`timescale 1ns/1ps
module card_reg_axi_slave (
  // clock and reset
  input logic sys_clk,
  input logic reset,
  // AXI4-Lite
  input logic [card_timing_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [card_timing_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // register file side
  output logic wr_en,
  output logic [7:0] wr_index,
  output logic [7:0] wr_data,
  input logic wr_hit,
  output logic [7:0] rd_index,
  input logic [31:0] rd_data,
  input logic rd_hit
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_full;
    logic [7:0] aw_index;
    logic w_full;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_state_t;

  axi_state_t st;
  axi_state_t next_st;
  logic commit;

  function automatic logic [7:0] to_index(input logic [card_timing_pkg::AXI_ADDR_W-1:0] a);
    return (a[11:10] != 2'h0) ? card_timing_pkg::IDX_UNMAPPED : a[9:2];
  endfunction

  assign commit = st.aw_full && st.w_full && !st.bvalid;

  always_comb begin
    next_st = st;
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_index = to_index(s_axi_awaddr);
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_full = 1'b1;
      next_st.w_byte = s_axi_wdata[7:0];
      next_st.w_lane0 = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (commit) begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = wr_hit ? card_timing_pkg::RESP_OKAY : card_timing_pkg::RESP_SLVERR;
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_data;
      next_st.rresp = rd_hit ? card_timing_pkg::RESP_OKAY : card_timing_pkg::RESP_SLVERR;
    end
    // readies stay low while a response is owed
    next_st.awready = !next_st.aw_full && !next_st.bvalid;
    next_st.wready = !next_st.w_full && !next_st.bvalid;
    next_st.arready = !next_st.rvalid;
    if (reset) begin
      next_st = '0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
      next_st.arready = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    st <= next_st;
  end

  assign wr_en = commit && st.w_lane0;
  assign wr_index = st.aw_index;
  assign wr_data = st.w_byte;
  assign rd_index = to_index(s_axi_araddr);
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
endmodule

/* File: card_cycle_timing_sequencer.sv */
// card socket cycle sequencer: setup, command and recovery timing of card accesses
// assumes host requests arrive on sys_clk; card inputs are asynchronous to it
`timescale 1ns/1ps
// Overview of operation
// - every phase lasts prescale factor times multiplier plus one internal clocks
// - phase factors come from the timer set chosen for the access
// - enables, space select, address and write data lead the strobe by setup count
// - command strobe stays active at least the command count
// - address and write data held for recovery count after the strobe ends
// - internal clock is four sevenths of input period, or equal when bypassed
// - wait stretches command; strobe ends two clocks after wait clears or later
// - word width flag counts only inside three clocks of cycle start
// - upper enable goes low on the next clock after the width flag is seen
// - timer set zero resets to 01h, 06h and 03h
module card_cycle_timing_sequencer (
  // clock and reset
  input logic sys_clk,
  input logic reset,
  // register bus
  input logic [card_timing_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [card_timing_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // host access request
  input logic acc_valid,
  output logic acc_ready,
  input logic acc_write,
  input logic acc_io,
  input logic acc_attr,
  input logic acc_word,
  input logic acc_timer_set,
  input logic [25:0] acc_addr,
  input logic [15:0] acc_wdata,
  // host access answer
  output logic acc_done,
  output logic [15:0] acc_rdata,
  output logic acc_width16,
  // card socket
  output logic [25:0] card_addr,
  input logic [15:0] card_data_in,
  output logic [15:0] card_data_out,
  output logic card_data_oe,
  output logic ce1_n,
  output logic ce2_n,
  output logic reg_n,
  output logic oe_n,
  output logic we_n,
  output logic iord_n,
  output logic iowr_n,
  input logic wait_n,
  input logic iois16_n
);
  typedef struct packed {
    card_timing_pkg::phase_t phase;
    logic [card_timing_pkg::COUNT_W-1:0] remaining;
    logic [card_timing_pkg::COUNT_W-1:0] command_clocks;
    logic [card_timing_pkg::COUNT_W-1:0] recovery_clocks;
    logic [1:0] wait_gap;
    logic [1:0] io16_age;
    logic io16_seen;
    logic ce2_armed;
    logic is_write;
    logic is_io;
    logic is_word;
    logic wait_extended;
    logic bypass;
    logic [card_timing_pkg::NUM_TIMING_REGS-1:0][7:0] timing;
    logic wait_meta;
    logic wait_n_s;
    logic iois16_meta;
    logic iois16_n_s;
    logic [15:0] data_meta;
    logic [15:0] data_s;
    logic acc_ready;
    logic acc_done;
    logic [15:0] acc_rdata;
    logic acc_width16;
    logic [25:0] card_addr;
    logic [15:0] card_data_out;
    logic card_data_oe;
    logic ce1_n;
    logic ce2_n;
    logic reg_n;
    logic oe_n;
    logic we_n;
    logic iord_n;
    logic iowr_n;
  } seq_state_t;

  seq_state_t st;
  seq_state_t next_st;
  logic tick;
  logic wr_en;
  logic [7:0] wr_index;
  logic [7:0] wr_data;
  logic wr_hit;
  logic [7:0] rd_index;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [2:0] set_base;
  logic [2:0] rd_slot;

  internal_clock_tick_gen u_tick (
    .sys_clk(sys_clk),
    .reset(reset),
    .bypass(st.bypass),
    .tick(tick)
  );

  card_reg_axi_slave u_axi (
    .sys_clk(sys_clk),
    .reset(reset),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_index(wr_index),
    .wr_data(wr_data),
    .wr_hit(wr_hit),
    .rd_index(rd_index),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  // register decode; status and captured data are read-only, writes there are dropped
  always_comb begin
    wr_hit = (wr_index >= card_timing_pkg::IDX_SETUP_SET0 &&
              wr_index <= card_timing_pkg::IDX_READ_DATA);
    rd_hit = (rd_index >= card_timing_pkg::IDX_SETUP_SET0 &&
              rd_index <= card_timing_pkg::IDX_READ_DATA);
    rd_slot = 3'(rd_index - card_timing_pkg::IDX_SETUP_SET0);
    rd_data = 32'h0;
    if (rd_index <= card_timing_pkg::IDX_RECOVERY_SET1 &&
        rd_index >= card_timing_pkg::IDX_SETUP_SET0) begin
      rd_data[7:0] = st.timing[rd_slot];
    end else if (rd_index == card_timing_pkg::IDX_CONTROL) begin
      rd_data[card_timing_pkg::CTRL_BYPASS_BIT] = st.bypass;
    end else if (rd_index == card_timing_pkg::IDX_STATUS) begin
      rd_data[card_timing_pkg::STATUS_PHASE_LSB +: 2] = st.phase;
      rd_data[card_timing_pkg::STATUS_BUSY_BIT] = (st.phase != card_timing_pkg::PH_IDLE);
      rd_data[card_timing_pkg::STATUS_WAIT_EXT_BIT] = st.wait_extended;
      rd_data[card_timing_pkg::STATUS_IO16_BIT] = st.io16_seen;
      rd_data[card_timing_pkg::STATUS_BYPASS_BIT] = st.bypass;
    end else if (rd_index == card_timing_pkg::IDX_READ_DATA) begin
      rd_data[15:0] = st.acc_rdata;
    end
  end

  // each access picks its timer set; set 1 sits right after set 0
  assign set_base = acc_timer_set ? 3'(card_timing_pkg::REGS_PER_SET) : 3'h0;

  always_comb begin
    next_st = st;
    next_st.acc_done = 1'b0;

    // two-flop synchronisers for the card pins
    next_st.wait_meta = wait_n;
    next_st.wait_n_s = st.wait_meta;
    next_st.iois16_meta = iois16_n;
    next_st.iois16_n_s = st.iois16_meta;
    next_st.data_meta = card_data_in;
    next_st.data_s = st.data_meta;

    // register writes; counts are latched per access, so a write mid-cycle waits
    for (int i = 0; i < card_timing_pkg::NUM_TIMING_REGS; i++) begin
      if (wr_en && wr_index == card_timing_pkg::IDX_SETUP_SET0 + 8'(i)) begin
        next_st.timing[i] = wr_data;
      end
    end
    if (wr_en && wr_index == card_timing_pkg::IDX_CONTROL) begin
      next_st.bypass = wr_data[card_timing_pkg::CTRL_BYPASS_BIT];
    end

    // word I/O width: flag counts only early in the cycle, upper enable a clock later
    if (st.phase != card_timing_pkg::PH_IDLE) begin
      if (tick && st.io16_age != card_timing_pkg::IOIS16_WINDOW_TICKS) begin
        next_st.io16_age = st.io16_age + 2'h1;
      end
      if (st.is_io && st.is_word && !st.io16_seen && !st.iois16_n_s &&
          st.io16_age != card_timing_pkg::IOIS16_WINDOW_TICKS) begin
        next_st.io16_seen = 1'b1;
        next_st.ce2_armed = 1'b1;
      end
      if (tick && st.ce2_armed) begin
        next_st.ce2_armed = 1'b0;
        next_st.ce2_n = 1'b0;
      end
    end

    unique case (st.phase)
      card_timing_pkg::PH_IDLE: begin
        if (acc_valid && st.acc_ready) begin
          next_st.phase = card_timing_pkg::PH_SETUP;
          next_st.acc_ready = 1'b0;
          // accepted between ticks, so one extra clock keeps the setup whole
          next_st.remaining = card_timing_pkg::phase_clocks(st.timing[set_base]) +
                              card_timing_pkg::SETUP_ENTRY_SLACK;
          next_st.command_clocks =
            card_timing_pkg::phase_clocks(st.timing[set_base + 3'h1]);
          next_st.recovery_clocks =
            card_timing_pkg::phase_clocks(st.timing[set_base + 3'h2]);
          next_st.is_write = acc_write;
          next_st.is_io = acc_io;
          next_st.is_word = acc_word;
          next_st.io16_age = 2'h0;
          next_st.io16_seen = 1'b0;
          next_st.ce2_armed = 1'b0;
          next_st.wait_extended = 1'b0;
          next_st.card_addr = acc_addr;
          next_st.reg_n = !acc_attr;
          next_st.ce1_n = 1'b0;
          next_st.ce2_n = !(acc_word && !acc_io);
          next_st.card_data_out = acc_wdata;
          next_st.card_data_oe = acc_write;
        end
      end
      card_timing_pkg::PH_SETUP: begin
        if (tick) begin
          if (st.remaining == card_timing_pkg::COUNT_W'(1)) begin
            next_st.phase = card_timing_pkg::PH_COMMAND;
            next_st.remaining = st.command_clocks;
            next_st.wait_gap = card_timing_pkg::WAIT_RELEASE_TICKS;
            next_st.oe_n = !(!st.is_io && !st.is_write);
            next_st.we_n = !(!st.is_io && st.is_write);
            next_st.iord_n = !(st.is_io && !st.is_write);
            next_st.iowr_n = !(st.is_io && st.is_write);
          end else begin
            next_st.remaining = st.remaining - card_timing_pkg::COUNT_W'(1);
          end
        end
      end
      card_timing_pkg::PH_COMMAND: begin
        if (tick && st.remaining != card_timing_pkg::COUNT_W'(1)) begin
          next_st.remaining = st.remaining - card_timing_pkg::COUNT_W'(1);
        end
        if (!st.wait_n_s) begin
          next_st.wait_gap = 2'h0;
          next_st.wait_extended = 1'b1;
        end else if (tick) begin
          if (st.remaining == card_timing_pkg::COUNT_W'(1) &&
              st.wait_gap == card_timing_pkg::WAIT_RELEASE_TICKS) begin
            next_st.phase = card_timing_pkg::PH_RECOVERY;
            next_st.remaining = st.recovery_clocks;
            next_st.oe_n = 1'b1;
            next_st.we_n = 1'b1;
            next_st.iord_n = 1'b1;
            next_st.iowr_n = 1'b1;
            if (!st.is_write) begin
              next_st.acc_rdata = st.data_s;
            end
          end else if (st.wait_gap != card_timing_pkg::WAIT_RELEASE_TICKS) begin
            next_st.wait_gap = st.wait_gap + 2'h1;
          end
        end
      end
      card_timing_pkg::PH_RECOVERY: begin
        if (tick) begin
          if (st.remaining == card_timing_pkg::COUNT_W'(1)) begin
            next_st.phase = card_timing_pkg::PH_IDLE;
            next_st.ce1_n = 1'b1;
            next_st.ce2_n = 1'b1;
            next_st.reg_n = 1'b1;
            next_st.card_data_oe = 1'b0;
            next_st.ce2_armed = 1'b0;
            next_st.acc_ready = 1'b1;
            next_st.acc_done = 1'b1;
            next_st.acc_width16 = st.is_io ? st.io16_seen : st.is_word;
          end else begin
            next_st.remaining = st.remaining - card_timing_pkg::COUNT_W'(1);
          end
        end
      end
    endcase

    if (reset) begin
      next_st = '0;
      next_st.timing[0] = card_timing_pkg::SETUP_SET0_RESET;
      next_st.timing[1] = card_timing_pkg::COMMAND_SET0_RESET;
      next_st.timing[2] = card_timing_pkg::RECOVERY_SET0_RESET;
      next_st.timing[3] = card_timing_pkg::TIMING_SET1_RESET;
      next_st.timing[4] = card_timing_pkg::TIMING_SET1_RESET;
      next_st.timing[5] = card_timing_pkg::TIMING_SET1_RESET;
      next_st.wait_meta = 1'b1;
      next_st.wait_n_s = 1'b1;
      next_st.iois16_meta = 1'b1;
      next_st.iois16_n_s = 1'b1;
      next_st.acc_ready = 1'b1;
      next_st.ce1_n = 1'b1;
      next_st.ce2_n = 1'b1;
      next_st.reg_n = 1'b1;
      next_st.oe_n = 1'b1;
      next_st.we_n = 1'b1;
      next_st.iord_n = 1'b1;
      next_st.iowr_n = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    st <= next_st;
  end

  assign acc_ready = st.acc_ready;
  assign acc_done = st.acc_done;
  assign acc_rdata = st.acc_rdata;
  assign acc_width16 = st.acc_width16;
  assign card_addr = st.card_addr;
  assign card_data_out = st.card_data_out;
  assign card_data_oe = st.card_data_oe;
  assign ce1_n = st.ce1_n;
  assign ce2_n = st.ce2_n;
  assign reg_n = st.reg_n;
  assign oe_n = st.oe_n;
  assign we_n = st.we_n;
  assign iord_n = st.iord_n;
  assign iowr_n = st.iowr_n;
endmodule

/* File: card_cycle_asserts.sv */
// checker for the card cycle sequencer, watching top-level ports only
// assumes one sys_clk domain and the synchronous reset
`timescale 1ns/1ps
module card_cycle_asserts (
  // clock and reset
  input logic sys_clk,
  input logic reset,
  // host side
  input logic acc_valid, acc_ready, acc_done,
  // card side
  input logic [25:0] card_addr,
  input logic [15:0] card_data_out,
  input logic card_data_oe, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n, wait_n, iois16_n
);
  wire idle = oe_n & we_n & iord_n & iowr_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_take_opens: assert property (
    acc_valid && acc_ready |=> !ce1_n && !acc_ready) else $error("no enable after take");
  a_setup_lead: assert property (
    $fell(idle) |-> $past(!ce1_n, 3) && $stable(card_addr)) else $error("strobe too early");
  a_addr_steady: assert property (
    !ce1_n && $past(!ce1_n) |-> $stable(card_addr) && (!card_data_oe || $stable(card_data_out)))
    else $error("address or data moved");
  a_cmd_min: assert property (
    $fell(idle) |-> !idle [*8]) else $error("strobe too short");
  a_recovery_hold: assert property (
    $rose(idle) |-> (!ce1_n && $stable(card_addr)) [*3]) else $error("hold too short");
  a_wait_holds: assert property (
    !idle && !$past(wait_n, 3) |=> !idle) else $error("strobe ended during wait");
  a_wait_release: assert property (
    $rose(idle) |-> $past(wait_n, 2) && $past(wait_n, 7)) else $error("early release");
  a_ce2_late: assert property (
    $fell(ce2_n) && $past(!ce1_n) |-> $past(!iois16_n, 3)) else $error("upper enable early");
  a_done_closes: assert property (
    acc_done |-> ce1_n && !card_data_oe && acc_ready ##1 !acc_done) else $error("bad done");
endmodule
bind card_cycle_timing_sequencer card_cycle_asserts card_cycle_asserts_i (.*);

/* File: card_socket_model.sv */
// card in the socket: sixteen words shared by memory and i/o space
// assumes the bench sets wait length and width flag between accesses
`timescale 1ns/1ps
module card_socket_model (
  // clock and strobes
  input logic sys_clk, ce1_n, oe_n, we_n, iord_n, iowr_n,
  // bus
  input logic [25:0] card_addr,
  input logic [15:0] card_data_out,
  output logic [15:0] card_data_in,
  // card status
  input logic io16,
  input logic [7:0] wait_len,
  output logic wait_n, iois16_n
);
  logic [15:0] mem [16];
  logic [7:0] cnt;
  wire rd_n = oe_n & iord_n;
  wire wr_n = we_n & iowr_n;
  initial begin
    card_data_in = 16'h0000;
    wait_n = 1'b1;
    iois16_n = 1'b1;
    cnt = 8'h00;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  always @(posedge sys_clk) begin
    // released bus toggles so stale data cannot pass
    card_data_in <= rd_n ? ~card_data_in : mem[card_addr[3:0]];
    iois16_n <= !(io16 && !ce1_n);
    if (!wr_n) mem[card_addr[3:0]] <= card_data_out;
    cnt <= (rd_n & wr_n) ? 8'h00 : cnt + 8'h01;
    wait_n <= !(wait_len != 8'h00 && cnt != 8'h00 && cnt <= wait_len);
  end
endmodule

/* File: card_cycle_timing_sequencer_bench.sv */
// bench: registers, timer sets, wait and width flag
// assumes the card model and a 100 MHz sys_clk
`timescale 1ns/1ps
`define CHK(n, e, v) begin checks_done++; if ((v) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", n, e, v); end end
module card_cycle_timing_sequencer_bench;
  logic sys_clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, acc_valid;
  logic acc_ready, acc_write, acc_io, acc_attr, acc_word, acc_timer_set, acc_done, acc_width16;
  logic card_data_oe, ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n, wait_n, iois16_n;
  logic io16, ce2_seen, rg;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [25:0] acc_addr, card_addr;
  logic [15:0] acc_wdata, acc_rdata, card_data_in, card_data_out;
  logic [7:0] wait_len;
  int failures, checks_done, cyc, tcp, s, c, r;
  card_cycle_timing_sequencer card_cycle_timing_sequencer_i (.*, .s_axi_wstrb(4'hf));
  card_socket_model card_socket_model_i (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic int tk(int n);
    return n * tcp / 10000;
  endfunction
  function automatic int ph(int v);
    return (v % 64) * (16 ** (v / 64)) + 1;
  endfunction
  function automatic logic [11:0] ad(logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK("rresp", er, s_axi_rresp)
    if (er == 2'h0) `CHK("rdata", {24'h000000, e}, s_axi_rdata)
  endtask
  // attribute space rides with timer set 1 to keep the task short
  task automatic acc(input logic w, io, wd, ts, input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    acc_write <= w;
    acc_io <= io;
    acc_word <= wd;
    acc_timer_set <= ts;
    acc_attr <= ts;
    acc_addr <= {22'h000000, a};
    acc_wdata <= d;
    acc_valid <= 1'b1;
    do @(posedge sys_clk); while (acc_ready !== 1'b1);
    acc_valid <= 1'b0;
    s = 0;
    c = 0;
    r = 0;
    ce2_seen = 1'b0;
    do begin @(posedge sys_clk); s++; end while (oe_n & we_n & iord_n & iowr_n);
    do begin
      @(posedge sys_clk);
      c++;
      ce2_seen |= !ce2_n;
      rg = reg_n;
    end while (!(oe_n & we_n & iord_n & iowr_n));
    do begin @(posedge sys_clk); r++; end while (acc_done !== 1'b1);
  endtask
  task automatic timing(int sv, int cv, int rv);
    `CHK("setup", 1'b1, s >= tk(sv) && s <= tk(sv + 1) + 2)
    `CHK("command", 1'b1, c >= tk(cv) - 1 && c <= tk(cv) + 2)
    `CHK("recovery", 1'b1, r >= tk(rv) - 1 && r <= tk(rv) + 2)
  endtask
  task automatic t_regs();
    rd(ad(8'h3a), 8'h01, 2'h0);
    rd(ad(8'h3b), 8'h06, 2'h0);
    rd(ad(8'h3c), 8'h03, 2'h0);
    wr(12'h800, 8'h5a, 2'h2);
    rd(12'h800, 8'h00, 2'h2);
  endtask
  task automatic t_default();
    acc(1'b1, 1'b0, 1'b1, 1'b0, 4'h5, 16'hbeef);
    timing(2, 7, 4);
    acc(1'b0, 1'b0, 1'b1, 1'b0, 4'h5, 16'h0000);
    timing(2, 7, 4);
    `CHK("read data", 16'hbeef, acc_rdata)
    `CHK("width", 1'b1, acc_width16)
    `CHK("reg select", 1'b1, rg)
  endtask
  task automatic t_set1();
    wr(ad(8'h3d), 8'h02, 2'h0);
    wr(ad(8'h3e), 8'h43, 2'h0);
    wr(ad(8'h3f), 8'h01, 2'h0);
    rd(ad(8'h3e), 8'h43, 2'h0);
    acc(1'b1, 1'b0, 1'b0, 1'b1, 4'h9, 16'h1234);
    timing(ph(8'h02), ph(8'h43), ph(8'h01));
    `CHK("reg select", 1'b0, rg)
    acc(1'b0, 1'b0, 1'b0, 1'b0, 4'h9, 16'h0000);
    `CHK("read data", 16'h1234, acc_rdata)
    `CHK("width", 1'b0, acc_width16)
  endtask
  task automatic t_wait();
    wait_len <= 8'h28;
    acc(1'b0, 1'b0, 1'b1, 1'b0, 4'h5, 16'h0000);
    wait_len <= 8'h00;
    `CHK("stretched", 1'b1, c >= 40 + tk(2) && c <= 48 + tk(3))
    `CHK("read data", 16'hbeef, acc_rdata)
  endtask
  task automatic t_io();
    io16 <= 1'b1;
    acc(1'b0, 1'b1, 1'b1, 1'b0, 4'h9, 16'h0000);
    `CHK("io width", 1'b1, acc_width16)
    `CHK("upper enable", 1'b1, ce2_seen)
    `CHK("io data", 16'h1234, acc_rdata)
    io16 <= 1'b0;
    acc(1'b1, 1'b1, 1'b1, 1'b0, 4'h3, 16'h00a5);
    `CHK("io width", 1'b0, acc_width16)
    `CHK("upper enable", 1'b0, ce2_seen)
  endtask
  task automatic t_bypass();
    wr(ad(8'h40), 8'h01, 2'h0);
    tcp = card_timing_pkg::INPUT_CLOCK_PERIOD_PS;
    acc(1'b0, 1'b0, 1'b0, 1'b0, 4'h3, 16'h0000);
    timing(2, 7, 4);
    `CHK("io write", 16'h00a5, acc_rdata)
    wr(ad(8'h40), 8'h00, 2'h0);
  endtask
  initial begin
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, acc_valid} = '0;
    {acc_write, acc_io, acc_attr, acc_word, acc_timer_set, io16, wait_len} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, acc_addr, acc_wdata} = '0;
    tcp = card_timing_pkg::INPUT_CLOCK_PERIOD_PS * 4 / 7;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_default();
    t_set1();
    t_wait();
    t_io();
    t_bypass();
    test_done();
  end
endmodule
